// file: core/dphy_timing_override.sv
// lane timing override bank behind an indirect address/data register pair
// assumes a synchronous byte register port; reads return data one cycle after rdEn
`timescale 1ns/100ps
module dphy_timing_override (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire dphy_timing_pkg::reg_req_t regReq,
	output logic [7:0] regRdData,
	output logic regRdValid,
	input wire dphy_timing_pkg::lane_timing_t autoTiming,
	output dphy_timing_pkg::lane_timing_t effTiming,
	output logic [7:0] overrideFlags
);
	import dphy_timing_pkg::*;

	logic [7:0] timing_reg [NUM_TIMING];
	logic [7:0] indirectAddr_reg;
	logic [7:0] rdData_reg;
	logic rdValid_reg;
	logic [7:0] rdData_next;

	// offset 0 belongs to a neighbouring register; bank starts at 1
	function automatic logic inBank(input logic [7:0] a);
		return (a >= CLK_LANE_ZERO_TIMING) && (a <= LOW_POWER_PULSE_TIMING);
	endfunction

	function automatic logic [2:0] bankIdx(input logic [7:0] a);
		logic [7:0] d;
		d = a - CLK_LANE_ZERO_TIMING;
		return d[2:0];
	endfunction

	wire selInBank = inBank(indirectAddr_reg);
	wire [2:0] selIdx = bankIdx(indirectAddr_reg);
	wire addrPortHit = regReq.addr == INDIRECT_ADDRESS_PORT;
	wire dataPortHit = regReq.addr == INDIRECT_DATA_PORT;
	wire addrWrite = regReq.wrEn && addrPortHit;
	wire dataWrite = regReq.wrEn && dataPortHit && selInBank;

	// packed copy of the bank, only so assertions can test it whole
	wire [8*NUM_TIMING-1:0] bankFlat = {timing_reg[7], timing_reg[6], timing_reg[5],
		timing_reg[4], timing_reg[3], timing_reg[2], timing_reg[1], timing_reg[0]};

	// address port selects the target before the data port is used
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			indirectAddr_reg <= INDIRECT_ADDR_RESET;
		end else if (addrWrite) begin
			indirectAddr_reg <= regReq.wrData;
		end
	end

	// whole byte stored regardless of flag, reserved bits included
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_TIMING; i++) begin
				timing_reg[i] <= TIMING_RESET;
			end
		end else if (dataWrite) begin
			timing_reg[selIdx] <= regReq.wrData;
		end
	end

	// unmapped indirect offsets read as zero and ignore writes
	always_comb begin
		rdData_next = 8'h00;
		if (addrPortHit) begin
			rdData_next = indirectAddr_reg;
		end else if (dataPortHit && selInBank) begin
			rdData_next = timing_reg[selIdx];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rdData_reg <= 8'h00;
			rdValid_reg <= 1'b0;
		end else begin
			rdValid_reg <= regReq.rdEn;
			if (regReq.rdEn) begin
				rdData_reg <= rdData_next;
			end
		end
	end

	assign regRdData = rdData_reg;
	assign regRdValid = rdValid_reg;

	timing_select #(.W(6)) selClkZero (
		.regValue(timing_reg[0]),
		.autoValue(autoTiming.clkZero),
		.effValue(effTiming.clkZero),
		.overrideOn(overrideFlags[0])
	);
	timing_select #(.W(4)) selClkTrail (
		.regValue(timing_reg[1]),
		.autoValue(autoTiming.clkTrail),
		.effValue(effTiming.clkTrail),
		.overrideOn(overrideFlags[1])
	);
	timing_select #(.W(6)) selClkPost (
		.regValue(timing_reg[2]),
		.autoValue(autoTiming.clkPost),
		.effValue(effTiming.clkPost),
		.overrideOn(overrideFlags[2])
	);
	timing_select #(.W(5)) selDataPrepare (
		.regValue(timing_reg[3]),
		.autoValue(autoTiming.dataPrepare),
		.effValue(effTiming.dataPrepare),
		.overrideOn(overrideFlags[3])
	);
	timing_select #(.W(5)) selDataZero (
		.regValue(timing_reg[4]),
		.autoValue(autoTiming.dataZero),
		.effValue(effTiming.dataZero),
		.overrideOn(overrideFlags[4])
	);
	timing_select #(.W(4)) selDataTrail (
		.regValue(timing_reg[5]),
		.autoValue(autoTiming.dataTrail),
		.effValue(effTiming.dataTrail),
		.overrideOn(overrideFlags[5])
	);
	timing_select #(.W(5)) selDataExit (
		.regValue(timing_reg[6]),
		.autoValue(autoTiming.dataExit),
		.effValue(effTiming.dataExit),
		.overrideOn(overrideFlags[6])
	);
	timing_select #(.W(4)) selLpPulse (
		.regValue(timing_reg[7]),
		.autoValue(autoTiming.lpPulse),
		.effValue(effTiming.lpPulse),
		.overrideOn(overrideFlags[7])
	);

	a_clk_zero_sel: assert property (@(posedge clk_sys) disable iff (!rst_b)
		effTiming.clkZero == (timing_reg[0][7] ? timing_reg[0][5:0] : autoTiming.clkZero))
		else $error("clock zero selection wrong");
	a_clk_trail_sel: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!timing_reg[1][7] |-> effTiming.clkTrail == autoTiming.clkTrail)
		else $error("clock trail not derived");
	a_clk_post_sel: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(regReq.wrEn && dataPortHit && indirectAddr_reg == CLK_LANE_POST_TIMING
		&& regReq.wrData[7]) |=> effTiming.clkPost == $past(regReq.wrData[5:0]))
		else $error("clock post override not applied");
	a_data_prep_sel: assert property (@(posedge clk_sys) disable iff (!rst_b)
		timing_reg[3][7] |-> effTiming.dataPrepare == timing_reg[3][4:0])
		else $error("data prepare override lost");
	a_data_zero_sel: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(regReq.wrEn && dataPortHit && indirectAddr_reg == DATA_LANE_ZERO_TIMING
		&& !regReq.wrData[7]) |=> effTiming.dataZero == autoTiming.dataZero)
		else $error("data zero should be derived");
	a_data_trail_sel: assert property (@(posedge clk_sys) disable iff (!rst_b)
		overrideFlags[5] |-> effTiming.dataTrail == timing_reg[5][3:0])
		else $error("data trail override lost");
	a_data_exit_sel: assert property (@(posedge clk_sys) disable iff (!rst_b)
		overrideFlags[6] == timing_reg[6][7] && (!overrideFlags[6]
		|| effTiming.dataExit == timing_reg[6][4:0]))
		else $error("data exit selection wrong");
	a_lp_pulse_sel: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!overrideFlags[7] |-> effTiming.lpPulse == autoTiming.lpPulse)
		else $error("low-power pulse not derived");
	a_addr_port_wr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		addrWrite |=> indirectAddr_reg == $past(regReq.wrData))
		else $error("address port not updated");
	a_data_port_rd: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(regReq.rdEn && dataPortHit && selInBank) |=> regRdValid
		&& regRdData == $past(timing_reg[selIdx]))
		else $error("data port read wrong");
	a_field_rw_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
		dataWrite |=> timing_reg[$past(selIdx)] == $past(regReq.wrData))
		else $error("field not stored");

	// steady state: each flag picks stored field or derived value
	a_clk_trail_ovr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		timing_reg[1][7] |-> effTiming.clkTrail == timing_reg[1][3:0])
		else $error("clock trail override lost");
	a_clk_post_ovr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		timing_reg[2][7] |-> effTiming.clkPost == timing_reg[2][5:0])
		else $error("clock post override lost");
	a_clk_post_auto: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!timing_reg[2][7] |-> effTiming.clkPost == autoTiming.clkPost)
		else $error("clock post not derived");
	a_data_prep_auto: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!timing_reg[3][7] |-> effTiming.dataPrepare == autoTiming.dataPrepare)
		else $error("data prepare not derived");
	a_data_zero_ovr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		timing_reg[4][7] |-> effTiming.dataZero == timing_reg[4][4:0])
		else $error("data zero override lost");
	a_data_zero_auto: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!timing_reg[4][7] |-> effTiming.dataZero == autoTiming.dataZero)
		else $error("data zero not derived");
	a_data_trail_auto: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!timing_reg[5][7] |-> effTiming.dataTrail == autoTiming.dataTrail)
		else $error("data trail not derived");
	a_lp_pulse_ovr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		timing_reg[7][7] |-> effTiming.lpPulse == timing_reg[7][3:0])
		else $error("low-power pulse override lost");

	// a bus write reaches the timing output one edge later
	a_clk_zero_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(dataWrite && indirectAddr_reg == CLK_LANE_ZERO_TIMING && regReq.wrData[7])
		|=> effTiming.clkZero == $past(regReq.wrData[5:0]))
		else $error("clock zero override write not applied");
	a_clk_trail_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(dataWrite && indirectAddr_reg == CLK_LANE_TRAIL_TIMING && regReq.wrData[7])
		|=> effTiming.clkTrail == $past(regReq.wrData[3:0]))
		else $error("clock trail override write not applied");
	a_data_prep_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(dataWrite && indirectAddr_reg == DATA_LANE_PREPARE_TIMING && regReq.wrData[7])
		|=> effTiming.dataPrepare == $past(regReq.wrData[4:0]))
		else $error("data prepare override write not applied");
	a_data_zero_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(dataWrite && indirectAddr_reg == DATA_LANE_ZERO_TIMING && regReq.wrData[7])
		|=> effTiming.dataZero == $past(regReq.wrData[4:0]))
		else $error("data zero override write not applied");
	a_data_trail_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(dataWrite && indirectAddr_reg == DATA_LANE_TRAIL_TIMING && regReq.wrData[7])
		|=> effTiming.dataTrail == $past(regReq.wrData[3:0]))
		else $error("data trail override write not applied");
	a_data_exit_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(dataWrite && indirectAddr_reg == DATA_LANE_EXIT_TIMING && regReq.wrData[7])
		|=> effTiming.dataExit == $past(regReq.wrData[4:0]))
		else $error("data exit override write not applied");
	a_lp_pulse_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(dataWrite && indirectAddr_reg == LOW_POWER_PULSE_TIMING && regReq.wrData[7])
		|=> effTiming.lpPulse == $past(regReq.wrData[3:0]))
		else $error("low-power pulse override write not applied");
	a_clk_zero_clr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(dataWrite && indirectAddr_reg == CLK_LANE_ZERO_TIMING && !regReq.wrData[7])
		|=> effTiming.clkZero == autoTiming.clkZero)
		else $error("clock zero should be derived");
	a_clk_trail_clr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(dataWrite && indirectAddr_reg == CLK_LANE_TRAIL_TIMING && !regReq.wrData[7])
		|=> effTiming.clkTrail == autoTiming.clkTrail)
		else $error("clock trail should be derived");
	a_clk_post_clr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(dataWrite && indirectAddr_reg == CLK_LANE_POST_TIMING && !regReq.wrData[7])
		|=> effTiming.clkPost == autoTiming.clkPost)
		else $error("clock post should be derived");
	a_data_prep_clr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(dataWrite && indirectAddr_reg == DATA_LANE_PREPARE_TIMING && !regReq.wrData[7])
		|=> effTiming.dataPrepare == autoTiming.dataPrepare)
		else $error("data prepare should be derived");
	a_data_trail_clr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(dataWrite && indirectAddr_reg == DATA_LANE_TRAIL_TIMING && !regReq.wrData[7])
		|=> effTiming.dataTrail == autoTiming.dataTrail)
		else $error("data trail should be derived");
	a_data_exit_clr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(dataWrite && indirectAddr_reg == DATA_LANE_EXIT_TIMING && !regReq.wrData[7])
		|=> effTiming.dataExit == autoTiming.dataExit)
		else $error("data exit should be derived");
	a_lp_pulse_clr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(dataWrite && indirectAddr_reg == LOW_POWER_PULSE_TIMING && !regReq.wrData[7])
		|=> effTiming.lpPulse == autoTiming.lpPulse)
		else $error("low-power pulse should be derived");

	// bus side of the indirect pair, then the all-flags-clear and flag mirror checks
	a_rd_valid_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
		regReq.rdEn |=> regRdValid)
		else $error("read answer missing");
	a_rd_valid_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!regReq.rdEn |=> !regRdValid)
		else $error("read answer without request");
	a_rd_data_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!regReq.rdEn |=> $stable(regRdData))
		else $error("read data moved without a read");
	a_addr_port_rd: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(regReq.rdEn && addrPortHit) |=> regRdData == $past(indirectAddr_reg))
		else $error("address port read wrong");
	a_unmapped_rd: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(regReq.rdEn && dataPortHit && !selInBank) |=> regRdData == 8'h00)
		else $error("unmapped offset read not zero");
	a_other_rd: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(regReq.rdEn && !addrPortHit && !dataPortHit) |=> regRdData == 8'h00)
		else $error("foreign address read not zero");
	a_addr_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!addrWrite |=> $stable(indirectAddr_reg))
		else $error("address port changed without a write");
	a_bank_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!dataWrite |=> $stable(bankFlat))
		else $error("bank changed without a write");
	a_unmapped_wr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(regReq.wrEn && dataPortHit && !selInBank) |=> $stable(bankFlat))
		else $error("unmapped offset write landed");
	a_all_auto: assert property (@(posedge clk_sys) disable iff (!rst_b)
		overrideFlags == 8'h00 |-> effTiming == autoTiming)
		else $error("stored field leaked with all flags clear");
	a_flag_mirror: assert property (@(posedge clk_sys) disable iff (!rst_b)
		overrideFlags == {timing_reg[7][7], timing_reg[6][7], timing_reg[5][7], timing_reg[4][7],
		timing_reg[3][7], timing_reg[2][7], timing_reg[1][7], timing_reg[0][7]})
		else $error("override flags do not mirror bit 7");
endmodule

// file: core/timing_select.sv
// one timing parameter: override flag picks stored field over derived value
// assumes the derived value is already in clk_sys domain
`timescale 1ns/100ps
module timing_select #(
	parameter int W = 6
) (
	input wire logic [7:0] regValue,
	input wire logic [W-1:0] autoValue,
	output logic [W-1:0] effValue,
	output logic overrideOn
);
	import dphy_timing_pkg::*;
	assign overrideOn = regValue[OVERRIDE_BIT];
	// stored field is inert unless the flag is set
	assign effValue = overrideOn ? regValue[W-1:0] : autoValue;
endmodule

// file: dv/dphy_timing_override_tb.sv
// self-checking bench for the lane timing override bank
// assumes the design carries its own assertions; drives ports on falling edges
`timescale 1ns/100ps
module dphy_timing_override_tb;
	import dphy_timing_pkg::*;
	logic clk_sys;
	logic rst_b;
	reg_req_t regReq;
	logic [7:0] regRdData;
	logic regRdValid;
	lane_timing_t autoTiming;
	lane_timing_t effTiming;
	logic [7:0] overrideFlags;
	lane_timing_t expT;
	logic [7:0] expF;
	logic [7:0] v;
	int num_errors;
	int num_checks;

	dphy_timing_override dut (.clk_sys(clk_sys), .rst_b(rst_b), .regReq(regReq),
		.regRdData(regRdData), .regRdValid(regRdValid), .autoTiming(autoTiming),
		.effTiming(effTiming), .overrideFlags(overrideFlags));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t byte got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chkT(input lane_timing_t got, input lane_timing_t exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t timing got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
		@(negedge clk_sys);
		regReq.wrEn = 1'b0;
	endtask

	// answer is registered, so it is looked at one edge after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		regReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
		@(negedge clk_sys);
		regReq.rdEn = 1'b0;
		chk8({7'h00, regRdValid}, 8'h01);
		chk8(regRdData, exp);
	endtask

	task automatic setExp(input int i, input logic [7:0] d);
		case (i)
			1: expT.clkZero = d[5:0];
			2: expT.clkTrail = d[3:0];
			3: expT.clkPost = d[5:0];
			4: expT.dataPrepare = d[4:0];
			5: expT.dataZero = d[4:0];
			6: expT.dataTrail = d[3:0];
			7: expT.dataExit = d[4:0];
			default: expT.lpPulse = d[3:0];
		endcase
	endtask

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		#100us;
		num_errors++;
		tally_and_finish();
	end

	initial begin
		rst_b = 1'b0;
		regReq = '0;
		autoTiming = 39'h435a1e7b4d;
		num_errors = 0;
		num_checks = 0;
		expT = autoTiming;
		expF = 8'h00;
		repeat (8) @(negedge clk_sys);
		rst_b = 1'b1;
		chkT(effTiming, expT);
		chk8(overrideFlags, expF);
		for (int i = 1; i <= NUM_TIMING; i++) begin
			// reserved bit 6 set too, it must not leak into the timing
			v = 8'(i * 11) | 8'h40;
			wr(INDIRECT_ADDRESS_PORT, 8'(i));
			rd(INDIRECT_ADDRESS_PORT, 8'(i));
			rd(INDIRECT_DATA_PORT, TIMING_RESET);
			wr(INDIRECT_DATA_PORT, v);
			chkT(effTiming, expT);
			rd(INDIRECT_DATA_PORT, v);
			v[OVERRIDE_BIT] = 1'b1;
			wr(INDIRECT_DATA_PORT, v);
			setExp(i, v);
			expF[i-1] = 1'b1;
			chkT(effTiming, expT);
			chk8(overrideFlags, expF);
		end
		wr(INDIRECT_ADDRESS_PORT, 8'h09);
		wr(INDIRECT_DATA_PORT, 8'hff);
		rd(INDIRECT_DATA_PORT, 8'h00);
		chk8(overrideFlags, expF);
		wr(INDIRECT_ADDRESS_PORT, LOW_POWER_PULSE_TIMING);
		wr(INDIRECT_DATA_PORT, 8'h0f);
		expT.lpPulse = autoTiming.lpPulse;
		expF[7] = 1'b0;
		chkT(effTiming, expT);
		chk8(overrideFlags, expF);
		@(negedge clk_sys);
		autoTiming = ~autoTiming;
		expT.lpPulse = autoTiming.lpPulse;
		#1;
		chkT(effTiming, expT);
		rd(INDIRECT_DATA_PORT, 8'h0f);
		// other direct address: write ignored, read gives zero with valid
		wr(8'h6e, 8'h55);
		rd(8'h6e, 8'h00);
		rd(INDIRECT_ADDRESS_PORT, LOW_POWER_PULSE_TIMING);
		// read and write together: the read returns the old byte
		@(negedge clk_sys);
		regReq = '{wrEn: 1'b1, rdEn: 1'b1, addr: INDIRECT_DATA_PORT, wrData: 8'h83};
		@(negedge clk_sys);
		regReq = '0;
		chk8({7'h00, regRdValid}, 8'h01);
		chk8(regRdData, 8'h0f);
		expT.lpPulse = 4'h3;
		expF[7] = 1'b1;
		chkT(effTiming, expT);
		chk8(overrideFlags, expF);
		// second reset in mid-run clears bank and address
		rst_b = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst_b = 1'b1;
		chkT(effTiming, autoTiming);
		chk8(overrideFlags, 8'h00);
		rd(INDIRECT_ADDRESS_PORT, INDIRECT_ADDR_RESET);
		wr(INDIRECT_ADDRESS_PORT, CLK_LANE_ZERO_TIMING);
		rd(INDIRECT_DATA_PORT, TIMING_RESET);
		tally_and_finish();
	end
endmodule

// file: shared/dphy_timing_pkg.sv
// constants and carriers for the lane timing override bank
// assumes a byte-wide direct register port in front of the indirect pair
package dphy_timing_pkg;
	localparam int REG_W = 8;
	localparam int NUM_TIMING = 8;
	localparam logic [7:0] INDIRECT_ADDRESS_PORT = 8'h6c;
	localparam logic [7:0] INDIRECT_DATA_PORT = 8'h6d;
	localparam logic [7:0] CLK_LANE_ZERO_TIMING = 8'h01;
	localparam logic [7:0] CLK_LANE_TRAIL_TIMING = 8'h02;
	localparam logic [7:0] CLK_LANE_POST_TIMING = 8'h03;
	localparam logic [7:0] DATA_LANE_PREPARE_TIMING = 8'h04;
	localparam logic [7:0] DATA_LANE_ZERO_TIMING = 8'h05;
	localparam logic [7:0] DATA_LANE_TRAIL_TIMING = 8'h06;
	localparam logic [7:0] DATA_LANE_EXIT_TIMING = 8'h07;
	localparam logic [7:0] LOW_POWER_PULSE_TIMING = 8'h08;
	localparam int OVERRIDE_BIT = 7;
	localparam logic [7:0] TIMING_RESET = 8'h00;
	localparam logic [7:0] INDIRECT_ADDR_RESET = 8'h00;

	typedef struct packed {
		logic [5:0] clkZero;
		logic [3:0] clkTrail;
		logic [5:0] clkPost;
		logic [4:0] dataPrepare;
		logic [4:0] dataZero;
		logic [3:0] dataTrail;
		logic [4:0] dataExit;
		logic [3:0] lpPulse;
	} lane_timing_t;

	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [7:0] addr;
		logic [7:0] wrData;
	} reg_req_t;
endpackage
